// ==== logic/sce_pkg.sv ====
package sce_pkg;

  // Register offsets
  localparam logic [7:0] SCE_STRAP_OFS = 8'h37;
  localparam logic [7:0] SCE_DIV_OFS = 8'h3a;
  localparam logic [7:0] SCE_EQ_OFS = 8'h3b;

  // Reset values
  localparam logic [7:0] SCE_STRAP_RST = 8'h00;
  localparam logic [7:0] SCE_DIV_RST = 8'h00;
  localparam logic [7:0] SCE_EQ_RST = 8'h00;

  // Writable bits of the divider register (bit 3 reserved)
  localparam logic [7:0] SCE_DIV_WMASK = 8'hf7;

  // Field positions, strap decode register
  localparam int SCE_RATE_DONE_BIT = 7;
  localparam int SCE_RATE_MSB = 6;
  localparam int SCE_RATE_LSB = 4;
  localparam int SCE_OUT_DONE_BIT = 3;
  localparam int SCE_OUT_MSB = 2;
  localparam int SCE_OUT_LSB = 0;

  // Field positions, divider register
  localparam int SCE_OV_MDIV_BIT = 7;
  localparam int SCE_MDIV_MSB = 6;
  localparam int SCE_MDIV_LSB = 4;
  localparam int SCE_OV_MSEL_BIT = 2;
  localparam int SCE_MSEL_MSB = 1;
  localparam int SCE_MSEL_LSB = 0;

  // Field position, equalizer status
  localparam int SCE_EQ_MSB = 5;

  // Timing
  localparam int SCE_CLK_PERIOD_PS = 25000;
  localparam int SCE_STRAP_SETTLE_NS = 1000;
  localparam int SCE_STRAP_SETTLE_CYC =
    (SCE_STRAP_SETTLE_NS * 1000 + SCE_CLK_PERIOD_PS - 1) / SCE_CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    SCE_LAYOUT_DUAL = 2'b00,
    SCE_LAYOUT_SWAP = 2'b01,
    SCE_LAYOUT_SINGLE = 2'b10,
    SCE_LAYOUT_REPLICATE = 2'b11
  } sce_layout_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sce_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
  } sce_strap_pin_t;

  typedef struct packed {
    logic bypass;
    logic [2:0] eq_stage_two;
    logic [2:0] eq_stage_one;
    logic [5:0] adaptive;
  } sce_eq_port_t;

endpackage

// ==== logic/sce_strap_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
module sce_strap_latch
  import sce_pkg::*;
#(
  parameter int SETTLE = SCE_STRAP_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire sce_strap_pin_t pin,
  output logic [2:0] code,
  output logic done
);

  localparam int CW = $clog2(SETTLE + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(SETTLE - 1);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [CW-1:0] cnt;
    logic [2:0] code;
    logic done;
  } sce_strap_st_t;

  sce_strap_st_t q_r;
  sce_strap_st_t q_nxt;

  // Sample pin decode, wait for it to settle, latch once
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.s1 = {pin.valid, pin.code};
    q_nxt.s2 = q_r.s1;
    if (!q_r.done)
    begin
      if (q_r.s2[3])
      begin
        if (q_r.cnt == CNT_LAST)
        begin
          q_nxt.code = q_r.s2[2:0];
          q_nxt.done = 1'b1;
        end
        else
        begin
          q_nxt.cnt = q_r.cnt + 1'b1;
        end
      end
      else
      begin
        q_nxt.cnt = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign code = q_r.code;
  assign done = q_r.done;

  done_sticky_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(done) |=> done [*8])
    else $error("strap latched flag dropped");

  code_frozen_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(done) |-> $stable(code))
    else $error("strap code changed after latch");

endmodule
`default_nettype wire

// ==== logic/sce_div_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module sce_div_select
  import sce_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] ctrl,
  input wire logic [2:0] internal_out_sel,
  input wire logic [1:0] pll_state_machine_in_sel,
  output logic [5:0] vco_out_ratio,
  output logic [3:0] vco_in_ratio
);

  typedef struct packed {
    logic [5:0] out_ratio;
    logic [3:0] in_ratio;
  } sce_div_st_t;

  sce_div_st_t q_r;
  sce_div_st_t q_nxt;
  logic [2:0] out_sel;
  logic [1:0] in_sel;

  always_comb
  begin
    q_nxt = q_r;
    if (ctrl[SCE_OV_MDIV_BIT])
      out_sel = ctrl[SCE_MDIV_MSB:SCE_MDIV_LSB];
    else
      out_sel = internal_out_sel;
    if (ctrl[SCE_OV_MSEL_BIT])
      in_sel = ctrl[SCE_MSEL_MSB:SCE_MSEL_LSB];
    else
      in_sel = pll_state_machine_in_sel;
    case (out_sel)
      3'h0: q_nxt.out_ratio = 6'h20;
      3'h1: q_nxt.out_ratio = 6'h10;
      3'h2: q_nxt.out_ratio = 6'h08;
      3'h3: q_nxt.out_ratio = 6'h04;
      3'h4, 3'h5: q_nxt.out_ratio = 6'h02;
      default: q_nxt.out_ratio = 6'h01;
    endcase
    case (in_sel)
      2'h0: q_nxt.in_ratio = 4'h1;
      2'h1: q_nxt.in_ratio = 4'h2;
      2'h2: q_nxt.in_ratio = 4'h4;
      default: q_nxt.in_ratio = 4'h8;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign vco_out_ratio = q_r.out_ratio;
  assign vco_in_ratio = q_r.in_ratio;

  in_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl[SCE_OV_MSEL_BIT] |=>
      vco_in_ratio == (4'h1 << $past(ctrl[SCE_MSEL_MSB:SCE_MSEL_LSB])))
    else $error("input divider ratio wrong under override");

endmodule
`default_nettype wire

// ==== logic/sce_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bit 7 of the strap register reads 0 until the rate pin is latched.
// - Bits 6-4 give the rate pin code: bit 1 picks 20 Mbps, bit 0 coax.
// - Bit 3 of the strap register reads 0 until the output pin latches.
// - Bits 2-0 give the output pin code: dual, swapped, single, copy.
// - Divider bit 7 set takes the written output divider, else internal.
// - Output divider code 0-3 divides by 32,16,8,4; 4-5 by 2; 6-7 by 1.
// - Divider bit 2 set takes the written input divider, else PLL pick.
// - Input divider code 0-3 divides the reference by 1, 2, 4 or 8.
// - With the loop bypassed, status shows the bypass stage two and one.
// - With the loop active, status shows the loop's current setting.
// - With the secondary port selected, status shows that port.
// - Reads of port copies follow the port select bit.
module sce_regs
  import sce_pkg::*;
#(
  parameter int STRAP_SETTLE = SCE_STRAP_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire sce_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire sce_strap_pin_t rate_cable_pin,
  input wire sce_strap_pin_t output_layout_pin,
  input wire logic secondary_port_select,
  input wire sce_eq_port_t eq_port0,
  input wire sce_eq_port_t eq_port1,
  input wire logic [2:0] internal_out_sel,
  input wire logic [1:0] pll_state_machine_in_sel,
  output logic rate_strap_latched,
  output logic [2:0] rate_cable_strap_decode,
  output logic output_strap_latched,
  output logic [2:0] output_layout_strap_decode,
  output logic link_rate_20m,
  output logic link_cable_coax,
  output sce_layout_t display_layout,
  output logic out_divider_override,
  output logic in_divider_override,
  output logic [5:0] vco_out_ratio,
  output logic [3:0] vco_in_ratio,
  output logic [5:0] equalizer_setting
);

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] rdata;
    logic rvalid;
    logic rate_20m;
    logic coax;
    sce_layout_t layout;
    logic [5:0] eq;
  } sce_top_st_t;

  sce_top_st_t q_r;
  sce_top_st_t q_nxt;
  logic [2:0] rate_code;
  logic rate_done;
  logic [2:0] out_code;
  logic out_done;
  logic [7:0] strap_word;
  logic [5:0] eq_p0;
  logic [5:0] eq_p1;
  logic [5:0] eq_sel;

  sce_strap_latch #(
    .SETTLE(STRAP_SETTLE)
  ) u_rate_strap (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(rate_cable_pin),
    .code(rate_code),
    .done(rate_done)
  );

  sce_strap_latch #(
    .SETTLE(STRAP_SETTLE)
  ) u_out_strap (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(output_layout_pin),
    .code(out_code),
    .done(out_done)
  );

  sce_div_select u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .ctrl(q_r.div),
    .internal_out_sel(internal_out_sel),
    .pll_state_machine_in_sel(pll_state_machine_in_sel),
    .vco_out_ratio(vco_out_ratio),
    .vco_in_ratio(vco_in_ratio)
  );

  // Assemble the strap word and the per-port equalizer values
  always_comb
  begin
    strap_word = SCE_STRAP_RST;
    strap_word[SCE_RATE_DONE_BIT] = rate_done;
    strap_word[SCE_RATE_MSB:SCE_RATE_LSB] = rate_code;
    strap_word[SCE_OUT_DONE_BIT] = out_done;
    strap_word[SCE_OUT_MSB:SCE_OUT_LSB] = out_code;
    if (eq_port0.bypass)
      eq_p0 = {eq_port0.eq_stage_two, eq_port0.eq_stage_one};
    else
      eq_p0 = eq_port0.adaptive;
    if (eq_port1.bypass)
      eq_p1 = {eq_port1.eq_stage_two, eq_port1.eq_stage_one};
    else
      eq_p1 = eq_port1.adaptive;
    if (secondary_port_select)
      eq_sel = eq_p1;
    else
      eq_sel = eq_p0;
  end

  // Register access and derived outputs
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rvalid = reg_req.rd;
    q_nxt.rdata = 8'h00;
    if (reg_req.wr && reg_req.addr == SCE_DIV_OFS)
      q_nxt.div = reg_req.wdata & SCE_DIV_WMASK;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        SCE_STRAP_OFS: q_nxt.rdata = strap_word;
        SCE_DIV_OFS: q_nxt.rdata = q_r.div;
        SCE_EQ_OFS: q_nxt.rdata = {2'h0, eq_sel};
        default: q_nxt.rdata = 8'h00;
      endcase
    end
    q_nxt.rate_20m = rate_code[1];
    q_nxt.coax = rate_code[0];
    q_nxt.layout = sce_layout_t'(out_code[1:0]);
    q_nxt.eq = eq_sel;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_r <= '0;
      q_r.div <= SCE_DIV_RST;
      q_r.eq <= SCE_EQ_RST[SCE_EQ_MSB:0];
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign reg_rvalid = q_r.rvalid;
  assign rate_strap_latched = rate_done;
  assign rate_cable_strap_decode = rate_code;
  assign output_strap_latched = out_done;
  assign output_layout_strap_decode = out_code;
  assign link_rate_20m = q_r.rate_20m;
  assign link_cable_coax = q_r.coax;
  assign display_layout = q_r.layout;
  assign out_divider_override = q_r.div[SCE_OV_MDIV_BIT];
  assign in_divider_override = q_r.div[SCE_OV_MSEL_BIT];
  assign equalizer_setting = q_r.eq;

  // Strap register reads and strap outputs
  rate_flag_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_STRAP_OFS && !rate_done |=>
      reg_rvalid && !reg_rdata[SCE_RATE_DONE_BIT])
    else $error("rate latched flag read as set too early");

  rate_flag_set_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_STRAP_OFS && rate_done |=>
      reg_rdata[SCE_RATE_DONE_BIT])
    else $error("rate latched flag read as clear after latch");

  rate_code_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_STRAP_OFS |=>
      reg_rdata[SCE_RATE_MSB:SCE_RATE_LSB] == $past(rate_code))
    else $error("rate strap code read back wrong");

  rate_outputs_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rate_done |=>
      {link_rate_20m, link_cable_coax} == $past(rate_code[1:0]))
    else $error("rate and cable outputs do not follow strap code");

  out_flag_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_STRAP_OFS |=>
      reg_rdata[SCE_OUT_DONE_BIT] == $past(out_done))
    else $error("output latched flag read back wrong");

  out_code_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_STRAP_OFS |=>
      reg_rdata[SCE_OUT_MSB:SCE_OUT_LSB] == $past(out_code))
    else $error("output strap code read back wrong");

  layout_decode_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    out_done |=> display_layout == sce_layout_t'(out_code[1:0]))
    else $error("display layout does not follow strap code");

  out_flag_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    out_done |=> out_done && $stable(out_code))
    else $error("output strap flag or code changed after latch");

  // Divider register and effective ratios
  div_write_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == SCE_DIV_OFS |=>
      q_r.div == ($past(reg_req.wdata) & SCE_DIV_WMASK))
    else $error("divider register write lost");

  div_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(reg_req.wr && reg_req.addr == SCE_DIV_OFS) |=> $stable(q_r.div))
    else $error("divider register changed without a write");

  div_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_DIV_OFS |=>
      reg_rdata == $past(q_r.div))
    else $error("divider register read back wrong");

  out_div_override_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    q_r.div[SCE_OV_MDIV_BIT] && q_r.div[SCE_MDIV_MSB:SCE_MDIV_LSB] == 3'h0
      && $stable(q_r.div) |=> vco_out_ratio == 6'h20)
    else $error("output divider override not honoured");

  out_div_shift_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    q_r.div[SCE_OV_MDIV_BIT] && !q_r.div[SCE_MDIV_MSB] |=>
      vco_out_ratio == (6'h20 >> $past(q_r.div[SCE_MDIV_MSB-1:SCE_MDIV_LSB])))
    else $error("output divider low codes decoded wrong");

  out_div_half_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    q_r.div[SCE_OV_MDIV_BIT] && q_r.div[SCE_MDIV_MSB:SCE_MDIV_LSB+1] == 2'b10
      |=> vco_out_ratio == 6'h02)
    else $error("output divider by two decode wrong");

  out_div_internal_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !q_r.div[SCE_OV_MDIV_BIT] && internal_out_sel[2:1] == 2'b11 |=>
      vco_out_ratio == 6'h01)
    else $error("output divider by one decode wrong");

  in_div_internal_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !q_r.div[SCE_OV_MSEL_BIT] |=>
      vco_in_ratio == (4'h1 << $past(pll_state_machine_in_sel)))
    else $error("input divider ignores pll state machine");

  // Equalizer status per port
  eq_bypass_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !secondary_port_select && eq_port0.bypass |=>
      equalizer_setting ==
        $past({eq_port0.eq_stage_two, eq_port0.eq_stage_one}))
    else $error("bypass equalizer value not reported");

  eq_p1_bypass_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    secondary_port_select && eq_port1.bypass |=>
      equalizer_setting ==
        $past({eq_port1.eq_stage_two, eq_port1.eq_stage_one}))
    else $error("port one bypass equalizer value not reported");

  eq_adaptive_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    secondary_port_select && !eq_port1.bypass |=>
      equalizer_setting == $past(eq_port1.adaptive))
    else $error("adaptive equalizer value not reported");

  eq_p0_adaptive_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !secondary_port_select && !eq_port0.bypass |=>
      equalizer_setting == $past(eq_port0.adaptive))
    else $error("port zero adaptive equalizer value not reported");

  eq_port_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_EQ_OFS |=>
      reg_rdata == {2'h0, $past(eq_sel)} && reg_rdata[7:6] == 2'h0)
    else $error("equalizer status read wrong port");

  // Read routing and strap register write protection
  port_sel_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_EQ_OFS && secondary_port_select |=>
      reg_rdata[5:0] == $past(eq_p1))
    else $error("port one copy not returned");

  eq_port0_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == SCE_EQ_OFS && !secondary_port_select |=>
      reg_rdata[5:0] == $past(eq_p0))
    else $error("port zero copy not returned");

  read_idle_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !reg_req.rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer without a read request");

  unmapped_read_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr != SCE_STRAP_OFS && reg_req.addr != SCE_DIV_OFS
      && reg_req.addr != SCE_EQ_OFS |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not answered with zero");

  strap_ro_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == SCE_STRAP_OFS && rate_done |=>
      rate_done && $stable(rate_cable_strap_decode))
    else $error("write disturbed strap fields");

endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sce_pkg::*;
;
  logic mclk;
  logic rst_n;
  sce_reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  sce_strap_pin_t rpin;
  sce_strap_pin_t opin;
  logic psel;
  sce_eq_port_t e0;
  sce_eq_port_t e1;
  logic [2:0] isel;
  logic [1:0] psm;
  logic rlat;
  logic [2:0] rdec;
  logic olat;
  logic [2:0] odec;
  logic r20m;
  logic coax;
  sce_layout_t layout;
  logic ovo;
  logic ovi;
  logic [5:0] oratio;
  logic [3:0] iratio;
  logic [5:0] eq;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] w;

  sce_regs #(.STRAP_SETTLE(4)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .rate_cable_pin(rpin), .output_layout_pin(opin),
    .secondary_port_select(psel), .eq_port0(e0), .eq_port1(e1),
    .internal_out_sel(isel), .pll_state_machine_in_sel(psm),
    .rate_strap_latched(rlat), .rate_cable_strap_decode(rdec),
    .output_strap_latched(olat), .output_layout_strap_decode(odec),
    .link_rate_20m(r20m), .link_cable_coax(coax), .display_layout(layout),
    .out_divider_override(ovo), .in_divider_override(ovi),
    .vco_out_ratio(oratio), .vco_in_ratio(iratio), .equalizer_setting(eq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
    int n;
    @(negedge mclk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 3)
    begin
      @(negedge mclk);
      n++;
    end
    chk("read strobe", {7'h0, rvalid}, 8'h01);
    chk(what, rdata, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  task automatic do_reset;
    @(negedge mclk);
    rst_n = 1'b0;
    rpin = '0;
    opin = '0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
  endtask

  task automatic eqc(input logic [5:0] exp);
    repeat (2) @(negedge mclk);
    chk("eq out", {2'b00, eq}, {2'b00, exp});
    rchk(SCE_EQ_OFS, {2'b00, exp}, "eq reg");
  endtask

  function automatic logic [7:0] out_div(input logic [2:0] c);
    if (c < 3'd4)
      return 8'h20 >> c;
    if (c < 3'd6)
      return 8'h02;
    return 8'h01;
  endfunction

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    rpin = '0;
    opin = '0;
    psel = 1'b0;
    e0 = '0;
    e1 = '0;
    isel = 3'h0;
    psm = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      do_reset();
      rchk(SCE_STRAP_OFS, 8'h00, "strap before");
      chk("pins rst", {rlat, rdec, olat, odec}, 8'h00);
      chk("div rst", {2'b00, oratio}, 8'h20);
      rpin = {1'b1, i[2:0]};
      opin = {1'b1, 3'(7 - i)};
      repeat (20) @(negedge mclk);
      w = {1'b1, i[2:0], 1'b1, 3'(7 - i)};
      rchk(SCE_STRAP_OFS, w, "strap");
      chk("strap pins", {rlat, rdec, olat, odec}, w);
      chk("rate", {6'h0, r20m, coax}, {6'h0, i[1:0]});
      chk("layout", {6'h0, layout}, {6'h0, 2'(7 - i)});
      rpin.code = ~i[2:0];
      opin.valid = 1'b0;
      wr(SCE_STRAP_OFS, 8'h00);
      repeat (8) @(negedge mclk);
      rchk(SCE_STRAP_OFS, w, "strap hold");
      chk("pins hold", {rlat, rdec, olat, odec}, w);
    end
    for (int i = 0; i < 8; i++)
    begin
      w = {1'b1, i[2:0], 1'b1, 1'b1, i[1:0]};
      wr(SCE_DIV_OFS, w);
      repeat (2) @(negedge mclk);
      chk("out ratio", {2'b00, oratio}, out_div(i[2:0]));
      chk("in ratio", {4'h0, iratio}, 8'h01 << i[1:0]);
      chk("overrides", {6'h0, ovo, ovi}, 8'h03);
      rchk(SCE_DIV_OFS, w & SCE_DIV_WMASK, "div reg");
    end
    isel = 3'd1;
    psm = 2'd2;
    wr(SCE_DIV_OFS, 8'h00);
    repeat (2) @(negedge mclk);
    chk("out ratio int", {2'b00, oratio}, 8'h10);
    chk("in ratio pll", {4'h0, iratio}, 8'h04);
    chk("overrides off", {6'h0, ovo, ovi}, 8'h00);
    isel = 3'd6;
    repeat (2) @(negedge mclk);
    chk("out ratio by one", {2'b00, oratio}, 8'h01);
    e0 = {1'b1, 3'd5, 3'd2, 6'h11};
    e1 = {1'b0, 3'd1, 3'd1, 6'h2c};
    eqc(6'h2a);
    e0.bypass = 1'b0;
    eqc(6'h11);
    psel = 1'b1;
    eqc(6'h2c);
    e1.bypass = 1'b1;
    wr(SCE_EQ_OFS, 8'hff);
    eqc(6'h09);
    wr(SCE_DIV_OFS, 8'hb6);
    rchk(SCE_DIV_OFS, 8'hb6, "div shared");
    chk("out ratio b6", {2'b00, oratio}, 8'h04);
    chk("in ratio b6", {4'h0, iratio}, 8'h04);
    rchk(SCE_STRAP_OFS, {1'b1, 3'd7, 1'b1, 3'd0}, "strap shared");
    psel = 1'b0;
    eqc(6'h11);
    rchk(8'h40, 8'h00, "unmapped");
    complete_run();
  end

  initial
  begin
    repeat (6000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
